// [common/fapc_pkg.sv]
// Constants and types for the flash address and program control block.
// Assumes a 100 MHz system clock and an external flash-clock tick source.
package fapc_pkg;

    localparam int unsigned CLK_HZ           = 100_000_000;
    localparam int unsigned CYC_PER_MS       = CLK_HZ / 1000;

    // Register indices; byte address is four times the index
    localparam logic [9:0]  IDX_PAGE         = 10'h0fc;
    localparam logic [9:0]  IDX_ROW          = 10'h0fd;
    localparam logic [9:0]  IDX_COL          = 10'h0fe;
    localparam logic [9:0]  IDX_PGCTL        = 10'h0ff;
    localparam logic [9:0]  IDX_STATUS       = 10'h0f8;

    // Field positions
    localparam int unsigned INFO_BIT         = 7;
    localparam int unsigned MASS_BIT         = 0;
    localparam int unsigned PAGE_BIT         = 1;
    localparam int unsigned ROW_BIT          = 2;
    localparam int unsigned ST_TMO_BIT       = 0;
    localparam int unsigned ST_REFUSE_BIT    = 1;
    localparam int unsigned ST_DONE_BIT      = 2;
    localparam int unsigned ST_BUSY_BIT      = 3;

    // Reset values
    localparam logic [7:0]  PAGE_RST         = 8'h00;
    localparam logic [2:0]  ROW_RST          = 3'h0;
    localparam logic [6:0]  COL_RST          = 7'h00;

    // Timing
    localparam int unsigned MASS_ERASE_MS    = 200;
    localparam int unsigned PAGE_ERASE_MS    = 10;
    localparam int unsigned MASS_ERASE_CYC   = MASS_ERASE_MS * CYC_PER_MS;
    localparam int unsigned PAGE_ERASE_CYC   = PAGE_ERASE_MS * CYC_PER_MS;
    localparam logic [11:0] ROW_TMO_TICKS    = 12'd2432;
    localparam logic [6:0]  COL_LAST         = 7'h7f;

    typedef enum logic [1:0] {
        OP_IDLE,
        OP_MASS,
        OP_PAGE,
        OP_ROW
    } fapc_op_e;

    typedef struct packed {
        logic       info;
        logic [6:0] page;
        logic [2:0] row;
        logic [6:0] col;
    } fapc_addr_s;

endpackage

// [rtl/fapc_top.sv]
// Flash page/row/column select registers and erase/row-program sequencer.
// Assumes APB from the CPU side, a one-cycle flash-clock tick from the divider,
// and a CPU that holds flash accesses while the matching wait output is high.
//
// Behaviour
// - Page select top bit steers accesses and erases to info page or main array
// - Low seven page bits pick main page; ignored while info page selected
// - With info page selected, page and full erase touch info page only
// - Three-bit row field picks row; upper five bits read-only zero
// - Info page selected limits row to zero or one
// - Seven-bit column field picks byte; bit seven read-only zero
// - Row programming starts at column and increments after each byte
// - Full erase runs about 200 ms, then its bit clears itself
// - Page erase runs about 10 ms, then its bit clears itself
// - Erase bit returns to zero on completion
// - Any erase stalls CPU flash reads and writes
// - Non-flash CPU accesses never stall during erase
// - Row programming stalls CPU flash reads until done or timeout
// - Row bit clears when column reaches 128 or on timeout
// - Row program aborts after 2432 flash clocks, setting timeout flag
// - Full erase refused while any block protect bit set
// - Successful erase or row program raises a completion event
module fapc_top #(
    parameter int unsigned MASS_ERASE_CYCLES = fapc_pkg::MASS_ERASE_CYC,
    parameter int unsigned PAGE_ERASE_CYCLES = fapc_pkg::PAGE_ERASE_CYC
) (
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic                    pready,
    output logic [31:0]             prdata,
    output logic                    pslverr,
    // Neighbouring blocks
    input  wire logic               fclk_tick,
    input  wire logic [7:0]         block_protect,
    // CPU flash accesses
    input  wire logic               cpu_flash_wr,
    input  wire logic [7:0]         cpu_wdata,
    output logic                    cpu_rd_wait,
    output logic                    cpu_wr_wait,
    // Flash array side
    output fapc_pkg::fapc_addr_s    arr_addr,
    output logic                    arr_wr,
    output logic [7:0]              arr_wdata,
    output logic                    arr_mass_erase,
    output logic                    arr_page_erase,
    output logic                    done_pulse
);

    fapc_pkg::fapc_op_e op;
    fapc_pkg::fapc_op_e next_op;
    logic [7:0]         page_select;
    logic [2:0]         row_select;
    logic [6:0]         column_select;
    logic [6:0]         col_cnt;
    logic [31:0]        erase_cnt;
    logic [11:0]        tmo_cnt;
    logic               row_program_timeout_flag;
    logic               refuse_flag;
    logic               done_flag;
    logic               done_evt;
    logic               tmo_evt;
    logic               refuse_evt;
    logic               apb_acc;
    logic               apb_wr;
    logic               pc_wr;
    logic               row_wr;
    logic               info_page_select;
    logic [2:0]         program_control_reg;

    function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
        hit = (a == {idx, 2'b00});
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        mapped = hit(a, fapc_pkg::IDX_PAGE) | hit(a, fapc_pkg::IDX_ROW)
               | hit(a, fapc_pkg::IDX_COL) | hit(a, fapc_pkg::IDX_PGCTL)
               | hit(a, fapc_pkg::IDX_STATUS);
    endfunction

    assign apb_acc          = psel & penable & pready;
    assign apb_wr           = apb_acc & pwrite & mapped(paddr);
    assign pc_wr            = apb_wr & hit(paddr, fapc_pkg::IDX_PGCTL);
    assign row_wr           = (op == fapc_pkg::OP_ROW) & cpu_flash_wr;
    assign info_page_select = page_select[fapc_pkg::INFO_BIT];
    // Control bits reflect the running operation, so they self-clear
    assign program_control_reg = {op == fapc_pkg::OP_ROW, op == fapc_pkg::OP_PAGE,
                                  op == fapc_pkg::OP_MASS};

    // One wait state per access keeps pready and prdata registered
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped(paddr);
            prdata  <= 32'h0000_0000;
            if (psel & penable & ~pready & ~pwrite) begin
                if (hit(paddr, fapc_pkg::IDX_ROW)) begin
                    prdata <= {29'h0000_0000, row_select};
                end
                if (hit(paddr, fapc_pkg::IDX_COL)) begin
                    prdata <= {25'h0000_0000, column_select};
                end
                if (hit(paddr, fapc_pkg::IDX_PAGE)) begin
                    prdata <= {24'h0000_00, page_select};
                end
                if (hit(paddr, fapc_pkg::IDX_PGCTL)) begin
                    prdata <= {29'h0000_0000, program_control_reg};
                end
                if (hit(paddr, fapc_pkg::IDX_STATUS)) begin
                    prdata <= {28'h0000_000, op != fapc_pkg::OP_IDLE, done_flag,
                               refuse_flag, row_program_timeout_flag};
                end
            end
        end
    end

    // Select registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            page_select   <= fapc_pkg::PAGE_RST;
            row_select    <= fapc_pkg::ROW_RST;
            column_select <= fapc_pkg::COL_RST;
        end else if (apb_wr) begin
            if (hit(paddr, fapc_pkg::IDX_PAGE)) begin
                page_select <= pwdata[7:0];
            end
            if (hit(paddr, fapc_pkg::IDX_ROW)) begin
                row_select <= pwdata[2:0];
            end
            if (hit(paddr, fapc_pkg::IDX_COL)) begin
                column_select <= pwdata[6:0];
            end
        end
    end

    // Operation sequencer
    always_comb begin
        next_op    = op;
        done_evt   = 1'b0;
        tmo_evt    = 1'b0;
        refuse_evt = 1'b0;
        case (op)
            fapc_pkg::OP_IDLE: begin
                if (pc_wr) begin
                    if (pwdata[fapc_pkg::MASS_BIT]) begin
                        if (|block_protect) begin
                            refuse_evt = 1'b1;
                        end else begin
                            next_op = fapc_pkg::OP_MASS;
                        end
                    end else if (pwdata[fapc_pkg::PAGE_BIT]) begin
                        next_op = fapc_pkg::OP_PAGE;
                    end else if (pwdata[fapc_pkg::ROW_BIT]) begin
                        next_op = fapc_pkg::OP_ROW;
                    end
                end
            end
            fapc_pkg::OP_MASS: begin
                if (erase_cnt == 32'(MASS_ERASE_CYCLES - 1)) begin
                    next_op  = fapc_pkg::OP_IDLE;
                    done_evt = 1'b1;
                end
            end
            fapc_pkg::OP_PAGE: begin
                if (erase_cnt == 32'(PAGE_ERASE_CYCLES - 1)) begin
                    next_op  = fapc_pkg::OP_IDLE;
                    done_evt = 1'b1;
                end
            end
            fapc_pkg::OP_ROW: begin
                if (row_wr && col_cnt == fapc_pkg::COL_LAST) begin
                    next_op  = fapc_pkg::OP_IDLE;
                    done_evt = 1'b1;
                end else if (fclk_tick && tmo_cnt == fapc_pkg::ROW_TMO_TICKS - 12'd1) begin
                    next_op = fapc_pkg::OP_IDLE;
                    tmo_evt = 1'b1;
                end
            end
            default: begin
                next_op = fapc_pkg::OP_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            op <= fapc_pkg::OP_IDLE;
        end else begin
            op <= next_op;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            erase_cnt <= 32'h0000_0000;
        end else if (next_op != op) begin
            erase_cnt <= 32'h0000_0000;
        end else begin
            erase_cnt <= erase_cnt + 32'h0000_0001;
        end
    end

    // Timeout counts flash-controller clocks, not system clocks
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tmo_cnt <= 12'h000;
        end else if (op != fapc_pkg::OP_ROW) begin
            tmo_cnt <= 12'h000;
        end else if (fclk_tick) begin
            tmo_cnt <= tmo_cnt + 12'h001;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            col_cnt <= fapc_pkg::COL_RST;
        end else if (op == fapc_pkg::OP_IDLE) begin
            col_cnt <= column_select;
        end else if (row_wr) begin
            col_cnt <= col_cnt + 7'h01;
        end
    end

    // Sticky status; a new event wins over a write-one clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            row_program_timeout_flag <= 1'b0;
            refuse_flag              <= 1'b0;
            done_flag                <= 1'b0;
        end else begin
            if (tmo_evt) begin
                row_program_timeout_flag <= 1'b1;
            end else if (apb_wr && hit(paddr, fapc_pkg::IDX_STATUS)
                         && pwdata[fapc_pkg::ST_TMO_BIT]) begin
                row_program_timeout_flag <= 1'b0;
            end
            if (refuse_evt) begin
                refuse_flag <= 1'b1;
            end else if (apb_wr && hit(paddr, fapc_pkg::IDX_STATUS)
                         && pwdata[fapc_pkg::ST_REFUSE_BIT]) begin
                refuse_flag <= 1'b0;
            end
            if (done_evt) begin
                done_flag <= 1'b1;
            end else if (apb_wr && hit(paddr, fapc_pkg::IDX_STATUS)
                         && pwdata[fapc_pkg::ST_DONE_BIT]) begin
                done_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            done_pulse <= 1'b0;
        end else begin
            done_pulse <= done_evt;
        end
    end

    // Waits apply only to flash accesses; other regions never see them
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_rd_wait    <= 1'b0;
            cpu_wr_wait    <= 1'b0;
            arr_mass_erase <= 1'b0;
            arr_page_erase <= 1'b0;
        end else begin
            cpu_wr_wait    <= next_op == fapc_pkg::OP_MASS || next_op == fapc_pkg::OP_PAGE;
            cpu_rd_wait    <= next_op != fapc_pkg::OP_IDLE;
            arr_mass_erase <= next_op == fapc_pkg::OP_MASS;
            arr_page_erase <= next_op == fapc_pkg::OP_PAGE;
        end
    end

    // Address is frozen while an erase runs, so late register writes are harmless
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            arr_addr  <= '0;
            arr_wr    <= 1'b0;
            arr_wdata <= 8'h00;
        end else begin
            arr_wr <= 1'b0;
            if (op == fapc_pkg::OP_IDLE) begin
                arr_addr.info <= info_page_select;
                arr_addr.page <= info_page_select ? 7'h00 : page_select[6:0];
                arr_addr.row  <= info_page_select ? {2'b00, row_select[0]} : row_select;
                arr_addr.col  <= column_select;
                if (cpu_flash_wr && next_op == fapc_pkg::OP_IDLE) begin
                    arr_wr    <= 1'b1;
                    arr_wdata <= cpu_wdata;
                end
            end else if (row_wr) begin
                arr_addr.col <= col_cnt;
                arr_wr       <= 1'b1;
                arr_wdata    <= cpu_wdata;
            end
        end
    end

    sequence seq_row_last;
        row_wr && col_cnt == fapc_pkg::COL_LAST;
    endsequence

    sequence seq_row_closed;
        op == fapc_pkg::OP_IDLE && done_pulse && !cpu_rd_wait;
    endsequence

    mass_refuse_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        op == fapc_pkg::OP_IDLE && pc_wr && pwdata[fapc_pkg::MASS_BIT] && |block_protect
        |=> !arr_mass_erase && refuse_flag)
        else $error("full erase started under protection");

    erase_done_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(arr_mass_erase) || $fell(arr_page_erase) |-> done_pulse)
        else $error("erase ended without completion event");

    erase_wait_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        arr_mass_erase || arr_page_erase |-> cpu_wr_wait && cpu_rd_wait)
        else $error("flash access not stalled during erase");

    idle_nowait_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        op == fapc_pkg::OP_IDLE |-> !cpu_wr_wait && !cpu_rd_wait)
        else $error("wait raised while idle");

    row_rdwait_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        op == fapc_pkg::OP_ROW |-> cpu_rd_wait && !cpu_wr_wait)
        else $error("row program wait wrong");

    col_incr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        row_wr && col_cnt != fapc_pkg::COL_LAST |=> arr_wr
        && arr_addr.col == $past(col_cnt) && col_cnt == $past(col_cnt) + 7'h01)
        else $error("column did not advance");

    row_end_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        seq_row_last |=> seq_row_closed)
        else $error("row program did not close at column 128");

    row_tmo_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        op == fapc_pkg::OP_ROW && fclk_tick && !row_wr
        && tmo_cnt == fapc_pkg::ROW_TMO_TICKS - 12'd1
        |=> op == fapc_pkg::OP_IDLE && row_program_timeout_flag && !done_pulse)
        else $error("row timeout not handled");

    info_row_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        arr_addr.info |-> arr_addr.row[2:1] == 2'b00 && arr_addr.page == 7'h00)
        else $error("info page address out of range");

    single_op_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        op != fapc_pkg::OP_IDLE && next_op != fapc_pkg::OP_IDLE |-> next_op == op)
        else $error("operation switched while busy");

endmodule

// [tb/fapc_cpu_model.sv]
// CPU-side partner: flash-clock tick source and byte writer for row programs.
// Assumes the bench pulses go for one cycle with the byte count on n_bytes.
module fapc_cpu_model #(
    parameter int unsigned TICK_DIV = 2
) (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // Bench control
    input  wire logic       go,
    input  wire logic [7:0] n_bytes,
    // Design side
    input  wire logic       cpu_wr_wait,
    output logic            fclk_tick,
    output logic            cpu_flash_wr,
    output logic [7:0]      cpu_wdata
);
    timeunit 1ns;
    timeprecision 1ps;

    int unsigned div_cnt;
    logic [7:0]  left;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt   <= 0;
            fclk_tick <= 1'b0;
        end else begin
            fclk_tick <= (div_cnt == TICK_DIV - 1);
            div_cnt   <= (div_cnt == TICK_DIV - 1) ? 0 : div_cnt + 1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            left         <= 8'h00;
            cpu_flash_wr <= 1'b0;
            cpu_wdata    <= 8'h00;
        end else if (go) begin
            left <= n_bytes;
        end else if (left != 8'h00 && !cpu_wr_wait && !cpu_flash_wr) begin
            cpu_flash_wr <= 1'b1;
            cpu_wdata    <= 8'ha0 + left;
            left         <= left - 8'h01;
        end else begin
            cpu_flash_wr <= 1'b0;
            // Idle data toggles so a stale byte is never mistaken for valid
            cpu_wdata    <= ~cpu_wdata;
        end
    end
endmodule

// [tb/test_flash_address_and_program_control.sv]
// Self-checking bench for the flash address and program control block.
// Assumes APB at 100 MHz and a CPU model supplying ticks and flash writes.
`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin \
    n_mismatch++; $display("wrong value %s expected %h seen %h", what, exp, got); end end
module test_flash_address_and_program_control;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [11:0] A_PAGE = {fapc_pkg::IDX_PAGE, 2'b00};
    localparam logic [11:0] A_ROW  = {fapc_pkg::IDX_ROW, 2'b00};
    localparam logic [11:0] A_COL  = {fapc_pkg::IDX_COL, 2'b00};
    localparam logic [11:0] A_CTL  = {fapc_pkg::IDX_PGCTL, 2'b00};
    localparam logic [11:0] A_STAT = {fapc_pkg::IDX_STATUS, 2'b00};

    logic sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [7:0]  block_protect = 8'h00, n_bytes = 8'h00;
    logic go = 1'b0, pready, pslverr, fclk_tick, cpu_flash_wr, cpu_rd_wait, cpu_wr_wait;
    logic arr_wr, arr_mass_erase, arr_page_erase, done_pulse;
    logic [31:0] prdata;
    logic [7:0]  cpu_wdata, arr_wdata;
    fapc_pkg::fapc_addr_s arr_addr, exp_a;
    fapc_pkg::fapc_addr_s wr_q[$];
    logic [7:0]  wd_q[$];
    int n_mismatch = 0, samples_checked = 0, erase_cyc = 0, done_cnt = 0, d0;

    always #5 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        if (arr_page_erase === 1'b1 || arr_mass_erase === 1'b1) erase_cyc++;
        if (done_pulse === 1'b1) done_cnt++;
        if (arr_wr === 1'b1) begin
            wr_q.push_back(arr_addr);
            wd_q.push_back(arr_wdata);
        end
    end

    fapc_top #(.MASS_ERASE_CYCLES(50), .PAGE_ERASE_CYCLES(20)) i_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .fclk_tick(fclk_tick),
        .block_protect(block_protect), .cpu_flash_wr(cpu_flash_wr),
        .cpu_wdata(cpu_wdata), .cpu_rd_wait(cpu_rd_wait), .cpu_wr_wait(cpu_wr_wait),
        .arr_addr(arr_addr), .arr_wr(arr_wr), .arr_wdata(arr_wdata),
        .arr_mass_erase(arr_mass_erase), .arr_page_erase(arr_page_erase),
        .done_pulse(done_pulse));

    fapc_cpu_model #(.TICK_DIV(2)) i_cpu (
        .sys_clk(sys_clk), .rst_n(rst_n), .go(go), .n_bytes(n_bytes),
        .cpu_wr_wait(cpu_wr_wait), .fclk_tick(fclk_tick),
        .cpu_flash_wr(cpu_flash_wr), .cpu_wdata(cpu_wdata));

    task automatic tally_and_finish();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int k;
        k = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1 && k < 20) begin
            @(posedge sys_clk);
            k++;
        end
        if (pready !== 1'b1) begin
            n_mismatch++;
            tally_and_finish();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, {24'h00_0000, d}, r, e);
    endtask

    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        `CHK(what, x, r)
    endtask

    // Bounded wait until no operation stalls the CPU
    task automatic wait_idle(input int lim);
        int k;
        k = 0;
        while (cpu_rd_wait !== 1'b0 && k < lim) begin
            @(negedge sys_clk);
            k++;
        end
        if (cpu_rd_wait !== 1'b0) begin
            n_mismatch++;
            tally_and_finish();
        end
        // Let the closing pulses reach the edge counters
        @(negedge sys_clk);
    endtask

    task automatic settle();
        @(negedge sys_clk);
        @(negedge sys_clk);
    endtask

    task automatic t_regs();
        logic [31:0] r;
        logic e;
        rd_chk("page", A_PAGE, 32'h0000_0000);
        rd_chk("row", A_ROW, 32'h0000_0000);
        rd_chk("col", A_COL, 32'h0000_0000);
        rd_chk("ctl", A_CTL, 32'h0000_0000);
        wr(A_PAGE, 8'hff);
        wr(A_ROW, 8'hff);
        wr(A_COL, 8'hff);
        rd_chk("page rw", A_PAGE, 32'h0000_00ff);
        rd_chk("row ro", A_ROW, 32'h0000_0007);
        rd_chk("col ro", A_COL, 32'h0000_007f);
        apb(1'b0, 12'h004, 32'h0000_0000, r, e);
        `CHK("unmapped err", 1'b1, e)
    endtask

    task automatic t_page();
        wr(A_PAGE, 8'h05);
        erase_cyc = 0;
        d0 = done_cnt;
        wr(A_CTL, 8'h02);
        settle();
        `CHK("page erase", 1'b1, arr_page_erase)
        `CHK("page no", 7'h05, arr_addr.page)
        `CHK("wr wait", 1'b1, cpu_wr_wait)
        `CHK("rd wait", 1'b1, cpu_rd_wait)
        rd_chk("ctl busy", A_CTL, 32'h0000_0002);
        wait_idle(100);
        `CHK("page cycles", 20, erase_cyc)
        `CHK("done", d0 + 1, done_cnt)
        rd_chk("ctl clear", A_CTL, 32'h0000_0000);
    endtask

    task automatic t_mass();
        wr(A_STAT, 8'h07);
        block_protect <= 8'h10;
        wr(A_CTL, 8'h01);
        settle();
        `CHK("refused", 1'b0, arr_mass_erase)
        rd_chk("refuse flag", A_STAT, 32'h0000_0002);
        block_protect <= 8'h00;
        wr(A_STAT, 8'h07);
        erase_cyc = 0;
        wr(A_CTL, 8'h01);
        settle();
        `CHK("mass erase", 1'b1, arr_mass_erase)
        wr(A_CTL, 8'h02);
        settle();
        `CHK("busy ignore", 1'b0, arr_page_erase)
        rd_chk("ctl mass", A_CTL, 32'h0000_0001);
        wait_idle(200);
        `CHK("mass cycles", 50, erase_cyc)
        rd_chk("ctl clear", A_CTL, 32'h0000_0000);
    endtask

    task automatic t_info();
        wr(A_PAGE, 8'h85);
        wr(A_ROW, 8'h01);
        wr(A_CTL, 8'h02);
        settle();
        exp_a = '{info: 1'b1, page: 7'h00, row: 3'h1, col: 7'h7f};
        `CHK("info addr", exp_a, arr_addr)
        wait_idle(100);
        wr(A_CTL, 8'h01);
        settle();
        `CHK("info mass", 1'b1, arr_mass_erase & arr_addr.info)
        wait_idle(200);
    endtask

    task automatic t_row();
        wr(A_PAGE, 8'h02);
        wr(A_ROW, 8'h03);
        wr(A_COL, 8'h7c);
        d0 = done_cnt;
        wr_q.delete();
        wd_q.delete();
        wr(A_CTL, 8'h04);
        settle();
        `CHK("row rd wait", 1'b1, cpu_rd_wait)
        `CHK("row wr wait", 1'b0, cpu_wr_wait)
        @(posedge sys_clk);
        go <= 1'b1;
        n_bytes <= 8'h04;
        @(posedge sys_clk);
        go <= 1'b0;
        wait_idle(200);
        `CHK("row count", 4, wr_q.size())
        for (int i = 0; i < 4 && i < wr_q.size(); i++) begin
            exp_a = '{info: 1'b0, page: 7'h02, row: 3'h3, col: 7'h7c + 7'(i)};
            `CHK("row addr", exp_a, wr_q[i])
            `CHK("row data", 8'ha4 - 8'(i), wd_q[i])
        end
        `CHK("row done", d0 + 1, done_cnt)
        rd_chk("ctl clear", A_CTL, 32'h0000_0000);
    endtask

    task automatic t_single();
        int k;
        wr(A_COL, 8'h11);
        wr_q.delete();
        wd_q.delete();
        @(posedge sys_clk);
        go <= 1'b1;
        n_bytes <= 8'h01;
        @(posedge sys_clk);
        go <= 1'b0;
        for (k = 0; k < 20 && wr_q.size() == 0; k++) @(negedge sys_clk);
        `CHK("single col", 7'h11, (wr_q.size() > 0) ? wr_q[0].col : 7'h00)
        `CHK("single data", 8'ha1, (wd_q.size() > 0) ? wd_q[0] : 8'h00)
        rd_chk("col kept", A_COL, 32'h0000_0011);
    endtask

    task automatic t_timeout();
        wr(A_STAT, 8'h07);
        wr(A_COL, 8'h00);
        d0 = done_cnt;
        wr(A_CTL, 8'h04);
        settle();
        wait_idle(6000);
        `CHK("no done", d0, done_cnt)
        rd_chk("ctl clear", A_CTL, 32'h0000_0000);
        rd_chk("tmo flag", A_STAT, 32'h0000_0001);
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_regs();
        t_page();
        t_mass();
        t_info();
        t_row();
        t_single();
        t_timeout();
        tally_and_finish();
    end
endmodule
